/* File: hw/phy_ident_and_an_advert_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module phy_ident_and_an_advert_regs
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  input wire logic strap_fast_full_duplex,
  input wire logic strap_fast,
  input wire logic strap_ten_full_duplex,
  input wire logic strap_ten,
  input wire logic an_complete,
  input wire logic [1:0] pause_resolved,
  output logic [15:0] adv_word,
  output logic adv_write
);

  typedef enum logic [2:0]
  {
    ST_PRE,
    ST_START,
    ST_OP,
    ST_ADDR,
    ST_TA,
    ST_READ,
    ST_WRITE
  } state_type;

  state_type state_ff;
  logic [phy_mgmt_pkg::ONES_W-1:0] ones_cnt_ff;
  logic [phy_mgmt_pkg::CNT_W-1:0] bit_cnt_ff;
  logic [1:0] op_ff;
  logic [phy_mgmt_pkg::FRAME_ADDR_W-1:0] addr_ff;
  logic [15:0] shift_ff;
  logic mdio_out_ff;
  logic mdio_oe_ff;
  logic adv_write_ff;
  logic rise;
  logic field_last;
  logic addressed;
  logic [4:0] reg_sel;
  logic [1:0] opcode_full;
  logic adv_wr_en;
  logic [15:0] wr_word;
  logic [15:0] adv_q;

  // ==========================================================
  // Helpers
  function automatic logic [phy_mgmt_pkg::CNT_W-1:0] field_end(input state_type st);
    logic [phy_mgmt_pkg::CNT_W-1:0] last;
    last = '0;
    case (st)
      ST_OP: last = phy_mgmt_pkg::CNT_W'(phy_mgmt_pkg::OP_W - 1);
      ST_ADDR: last = phy_mgmt_pkg::CNT_W'(phy_mgmt_pkg::FRAME_ADDR_W - 1);
      ST_TA: last = phy_mgmt_pkg::CNT_W'(phy_mgmt_pkg::TA_W - 1);
      ST_READ: last = phy_mgmt_pkg::CNT_W'(phy_mgmt_pkg::REG_W - 1);
      ST_WRITE: last = phy_mgmt_pkg::CNT_W'(phy_mgmt_pkg::REG_W - 1);
      default: last = '0;
    endcase
    return last;
  endfunction

  function automatic logic [15:0] read_value(input logic [4:0] sel,
                                             input logic [15:0] adv,
                                             input logic done,
                                             input logic [1:0] pause);
    logic [15:0] val;
    val = '0;
    if (sel == phy_mgmt_pkg::BASIC_MODE_STATUS_ADDR)
    begin
      val[phy_mgmt_pkg::AN_COMPLETE_BIT] = done;
    end
    else if (sel == phy_mgmt_pkg::PHY_IDENT_HIGH_ADDR)
    begin
      val = phy_mgmt_pkg::ORG_ID_BITS[phy_mgmt_pkg::ORG_HIGH_FIRST:phy_mgmt_pkg::ORG_HIGH_LAST];
    end
    else if (sel == phy_mgmt_pkg::PHY_IDENT_LOW_ADDR)
    begin
      val = {phy_mgmt_pkg::ORG_ID_BITS[phy_mgmt_pkg::ORG_LOW_FIRST:phy_mgmt_pkg::ORG_LOW_LAST],
             phy_mgmt_pkg::VENDOR_MODEL,
             phy_mgmt_pkg::MODEL_REV};
    end
    else if (sel == phy_mgmt_pkg::AUTONEG_ADVERTISEMENT_ADDR)
    begin
      val = adv;
    end
    else if (sel == phy_mgmt_pkg::TRANSCEIVER_CONTROL_ADDR)
    begin
      val[phy_mgmt_pkg::PAUSE_RES_HI:phy_mgmt_pkg::PAUSE_RES_LO] = pause;
    end
    else
    begin
      val = '0;
    end
    return val;
  endfunction

  // ==========================================================
  // Management clock edge
  mdc_edge_detect u_mdc_edge
  (
    .clock(clock),
    .rst_n(rst_n),
    .mdc(mdc),
    .mdc_rise(rise)
  );

  assign field_last = (bit_cnt_ff == field_end(state_ff));
  assign addressed = (addr_ff[phy_mgmt_pkg::FRAME_ADDR_W-1:phy_mgmt_pkg::ADDR_W] == phy_addr);
  assign reg_sel = addr_ff[phy_mgmt_pkg::ADDR_W-1:0];
  assign opcode_full = {op_ff[0], mdio_in};
  assign wr_word = {shift_ff[14:0], mdio_in};

  // ==========================================================
  // Frame sequencer
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= ST_PRE;
    end
    else if (rise)
    begin
      case (state_ff)
        ST_PRE:
        begin
          if (!mdio_in && ones_cnt_ff >= phy_mgmt_pkg::ONES_W'(phy_mgmt_pkg::PREAMBLE_BITS))
          begin
            state_ff <= ST_START;
          end
        end
        ST_START:
        begin
          state_ff <= mdio_in ? ST_OP : ST_PRE;
        end
        ST_OP:
        begin
          if (field_last)
          begin
            if (opcode_full == phy_mgmt_pkg::OP_READ || opcode_full == phy_mgmt_pkg::OP_WRITE)
            begin
              state_ff <= ST_ADDR;
            end
            else
            begin
              state_ff <= ST_PRE;
            end
          end
        end
        ST_ADDR:
        begin
          if (field_last)
          begin
            state_ff <= ST_TA;
          end
        end
        ST_TA:
        begin
          if (field_last)
          begin
            state_ff <= (op_ff == phy_mgmt_pkg::OP_READ) ? ST_READ : ST_WRITE;
          end
        end
        ST_READ, ST_WRITE:
        begin
          if (field_last)
          begin
            state_ff <= ST_PRE;
          end
        end
        default:
        begin
          state_ff <= ST_PRE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt_ff <= '0;
    end
    else if (rise)
    begin
      if (state_ff == ST_PRE || state_ff == ST_START || field_last)
      begin
        bit_cnt_ff <= '0;
      end
      else
      begin
        bit_cnt_ff <= bit_cnt_ff + 1'b1;
      end
    end
  end

  // Full preamble is needed only after reset or a dropped frame
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ones_cnt_ff <= '0;
    end
    else if (rise)
    begin
      if (state_ff == ST_PRE)
      begin
        if (!mdio_in)
        begin
          ones_cnt_ff <= '0;
        end
        else if (ones_cnt_ff < phy_mgmt_pkg::ONES_W'(phy_mgmt_pkg::PREAMBLE_BITS))
        begin
          ones_cnt_ff <= ones_cnt_ff + 1'b1;
        end
      end
      else if (state_ff == ST_START && !mdio_in)
      begin
        ones_cnt_ff <= '0;
      end
      else if (state_ff == ST_OP && field_last && opcode_full != phy_mgmt_pkg::OP_READ
               && opcode_full != phy_mgmt_pkg::OP_WRITE)
      begin
        ones_cnt_ff <= '0;
      end
      else if ((state_ff == ST_READ || state_ff == ST_WRITE) && field_last)
      begin
        ones_cnt_ff <= phy_mgmt_pkg::ONES_W'(phy_mgmt_pkg::PREAMBLE_BITS);
      end
    end
  end

  // ==========================================================
  // Header capture
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_ff <= '0;
      addr_ff <= '0;
    end
    else if (rise)
    begin
      if (state_ff == ST_OP)
      begin
        op_ff <= opcode_full;
      end
      if (state_ff == ST_ADDR)
      begin
        addr_ff <= {addr_ff[phy_mgmt_pkg::FRAME_ADDR_W-2:0], mdio_in};
      end
    end
  end

  // ==========================================================
  // Data shifter
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_ff <= '0;
    end
    else if (rise)
    begin
      if (state_ff == ST_TA && bit_cnt_ff == '0)
      begin
        // Snapshot once, so a live status bit cannot tear mid-word
        shift_ff <= read_value(reg_sel, adv_q, an_complete, pause_resolved);
      end
      else if (state_ff == ST_READ)
      begin
        shift_ff <= {shift_ff[14:0], 1'b0};
      end
      else if (state_ff == ST_WRITE)
      begin
        shift_ff <= wr_word;
      end
    end
  end

  // ==========================================================
  // Pin drive
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mdio_oe_ff <= 1'b0;
      mdio_out_ff <= 1'b0;
    end
    else if (rise)
    begin
      if (state_ff == ST_TA && op_ff == phy_mgmt_pkg::OP_READ && addressed)
      begin
        mdio_oe_ff <= 1'b1;
        mdio_out_ff <= field_last ? shift_ff[15] : 1'b0;
      end
      else if (state_ff == ST_READ && mdio_oe_ff && !field_last)
      begin
        mdio_out_ff <= shift_ff[14];
      end
      else
      begin
        mdio_oe_ff <= 1'b0;
        mdio_out_ff <= 1'b0;
      end
    end
  end

  assign mdio_out = mdio_out_ff;
  assign mdio_oe = mdio_oe_ff;

  // ==========================================================
  // Advertisement register
  assign adv_wr_en = rise && state_ff == ST_WRITE && field_last && addressed
                     && reg_sel == phy_mgmt_pkg::AUTONEG_ADVERTISEMENT_ADDR;

  // Writes to other addresses, ident low included, are dropped
  autoneg_advert_reg u_advert
  (
    .clock(clock),
    .rst_n(rst_n),
    .wr_en(adv_wr_en),
    .wr_data(wr_word),
    .strap_abilities({strap_fast_full_duplex, strap_fast, strap_ten_full_duplex, strap_ten}),
    .adv_q(adv_q)
  );

  // Engine sees the new word one edge after the write; a restart is up to software
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      adv_write_ff <= 1'b0;
    end
    else
    begin
      adv_write_ff <= adv_wr_en;
    end
  end

  assign adv_word = adv_q;
  assign adv_write = adv_write_ff;

endmodule
`default_nettype wire

/* File: hw/phy_mgmt_pkg.sv */
package phy_mgmt_pkg;

  // ==========================================================
  // Frame layout
  localparam int REG_W = 16;
  localparam int ADDR_W = 5;
  localparam int FRAME_ADDR_W = 10;
  localparam int OP_W = 2;
  localparam int TA_W = 2;
  localparam int CNT_W = 4;
  localparam int PREAMBLE_BITS = 32;
  localparam int ONES_W = 6;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  // ==========================================================
  // Register map
  localparam logic [4:0] BASIC_MODE_STATUS_ADDR = 5'h01;
  localparam logic [4:0] PHY_IDENT_HIGH_ADDR = 5'h02;
  localparam logic [4:0] PHY_IDENT_LOW_ADDR = 5'h03;
  localparam logic [4:0] AUTONEG_ADVERTISEMENT_ADDR = 5'h04;
  localparam logic [4:0] TRANSCEIVER_CONTROL_ADDR = 5'h19;

  // ==========================================================
  // Field positions
  localparam int AN_COMPLETE_BIT = 5;
  localparam int PAUSE_RES_HI = 13;
  localparam int PAUSE_RES_LO = 12;
  localparam int ADV_STRAP_HI = 8;
  localparam int ADV_STRAP_LO = 5;
  localparam int ORG_HIGH_FIRST = 3;
  localparam int ORG_HIGH_LAST = 18;
  localparam int ORG_LOW_FIRST = 19;
  localparam int ORG_LOW_LAST = 24;

  // ==========================================================
  // Advertisement layout
  localparam logic [15:0] ADV_RESET = 16'h0001;
  // Bits 14, 12 and 9 are never stored
  localparam logic [15:0] ADV_WRITE_MASK = 16'hadff;

  // ==========================================================
  // Identity, values are arbitrary
  localparam logic [1:24] ORG_ID_BITS = 24'h5a3c96;
  localparam logic [5:0] VENDOR_MODEL = 6'h2a;
  localparam logic [3:0] MODEL_REV = 4'h5;

endpackage

/* File: hw/mdc_edge_detect.sv */
`timescale 1ns/1ps
`default_nettype none
module mdc_edge_detect
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic mdc,
  output logic mdc_rise
);

  logic mdc_q_ff;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Starts high, so a clock parked high over reset gives no false rise
      mdc_q_ff <= 1'h1;
    end
    else
    begin
      mdc_q_ff <= mdc;
    end
  end

  assign mdc_rise = mdc & ~mdc_q_ff;

endmodule
`default_nettype wire

/* File: hw/autoneg_advert_reg.sv */
`timescale 1ns/1ps
`default_nettype none
module autoneg_advert_reg
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic [3:0] strap_abilities,
  output logic [15:0] adv_q
);

  logic [15:0] adv_ff;
  logic strap_done_ff;

  // Straps are caught on the first edge after release, never under reset
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_done_ff <= 1'b0;
    end
    else
    begin
      strap_done_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      adv_ff <= phy_mgmt_pkg::ADV_RESET;
    end
    else if (!strap_done_ff)
    begin
      adv_ff[phy_mgmt_pkg::ADV_STRAP_HI:phy_mgmt_pkg::ADV_STRAP_LO] <= strap_abilities;
    end
    else if (wr_en)
    begin
      adv_ff <= wr_data & phy_mgmt_pkg::ADV_WRITE_MASK;
    end
  end

  assign adv_q = adv_ff;

endmodule
`default_nettype wire

/* File: test/adv_regs_checker_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module adv_regs_checker
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic strap_fast_full_duplex,
  input wire logic strap_fast,
  input wire logic strap_ten_full_duplex,
  input wire logic strap_ten,
  input wire logic [15:0] adv_word,
  input wire logic adv_write
);
  logic live_ff;
  // ==========================================================
  // First edge after release loads straps, it is not a write
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      live_ff <= 1'h0;
    else
      live_ff <= 1'h1;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Properties
  AST_RO_BITS: assert property (adv_word[14] == 1'h0 && adv_word[9] == 1'h0)
    else $error("read-only advertisement bit set");
  AST_RSVD_BIT: assert property (adv_word[12] == 1'h0)
    else $error("reserved advertisement bit set");
  AST_RESET_VALUE: assert property (!live_ff |-> adv_word == 16'h0001)
    else $error("advertisement reset value wrong");
  AST_STRAP_LOAD: assert property (!live_ff |=> adv_word[8:5] == {$past(strap_fast_full_duplex),
    $past(strap_fast), $past(strap_ten_full_duplex), $past(strap_ten)})
    else $error("strap abilities not loaded");
  AST_CHANGE_PULSE: assert property (live_ff && $past(live_ff) && $changed(adv_word) |-> adv_write)
    else $error("advertisement changed without pulse");
  AST_PULSE_SINGLE: assert property (adv_write |=> !adv_write)
    else $error("write pulse too long");
  AST_PULSE_STABLE: assert property (adv_write |=> $stable(adv_word))
    else $error("advertisement moved during pulse");
  AST_TA_DRIVE: assert property ($rose(mdio_oe) |-> !mdio_out ##1 mdio_oe [*3])
    else $error("turnaround drive wrong");
  AST_IDLE_OUT: assert property (!mdio_oe |-> !mdio_out)
    else $error("data out while released");
endmodule
bind phy_ident_and_an_advert_regs adv_regs_checker adv_regs_checker_i (.clock(clock),
  .rst_n(rst_n), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
  .strap_fast_full_duplex(strap_fast_full_duplex), .strap_fast(strap_fast),
  .strap_ten_full_duplex(strap_ten_full_duplex), .strap_ten(strap_ten),
  .adv_word(adv_word), .adv_write(adv_write));
`default_nettype wire

/* File: test/mgmt_station_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mgmt_station_model
(
  input wire logic clock,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic mdc,
  output logic mdio_in
);
  logic drv = 1'h1;
  logic own = 1'h1;
  initial mdc = 1'h0;
  // Released line shows the inverse of the last driven value
  assign mdio_in = mdio_oe ? mdio_out : (own ? drv : ~drv);
  // ==========================================================
  // One bit: 3 clocks low, 3 high, data changes only at the fall
  task automatic put_bit(input logic v, input logic o, output logic s);
    @(negedge clock);
    mdc = 1'h0;
    drv = v;
    own = o;
    repeat (3) @(negedge clock);
    s = mdio_in;
    mdc = 1'h1;
    repeat (2) @(negedge clock);
  endtask
  // Renegotiation after an early write is left to the caller
  task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] pa,
    input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] hdr;
    logic s;
    rd = 16'h0;
    repeat (pre) put_bit(1'h1, 1'h1, s);
    hdr = {2'h1, op, pa, ra, 2'h2, wd};
    for (int i = 31; i >= 0; i--)
    begin
      put_bit(hdr[i], op == phy_mgmt_pkg::OP_WRITE || i > 17, s);
      if (i < 16)
        rd[i] = s;
    end
  endtask
endmodule
`default_nettype wire

/* File: test/tb_phy_ident_and_an_advert_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_phy_ident_and_an_advert_regs;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic mdc, mdio_in, mdio_out, mdio_oe, adv_write;
  logic an_complete = 1'h0;
  logic [4:0] phy_addr = 5'h0;
  logic [3:0] straps = 4'h0;
  logic [1:0] pause_resolved = 2'h0;
  logic [15:0] adv_word, adv_m, rd, d;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int pre = 32;
  phy_ident_and_an_advert_regs phy_ident_and_an_advert_regs_i (.clock(clock), .rst_n(rst_n),
    .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(phy_addr),
    .strap_fast_full_duplex(straps[3]), .strap_fast(straps[2]),
    .strap_ten_full_duplex(straps[1]), .strap_ten(straps[0]), .an_complete(an_complete),
    .pause_resolved(pause_resolved), .adv_word(adv_word), .adv_write(adv_write));
  mgmt_station_model mgmt_station_model_i (.clock(clock), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .mdc(mdc), .mdio_in(mdio_in));
  initial
  begin
    forever #5 clock = ~clock;
  end
  // ==========================================================
  // Checking and closing
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      complete_run();
    end
  end
  // ==========================================================
  // Bus tasks; full preamble only after reset or a dropped frame
  task automatic rd_reg(input logic [4:0] ra, input logic [15:0] exp, input string what);
    mgmt_station_model_i.frame(pre, phy_mgmt_pkg::OP_READ, phy_addr, ra, 16'h0, rd);
    pre = 0;
    check(what, rd, exp);
  endtask
  task automatic wr_reg(input logic [4:0] ra, input logic [15:0] wd);
    mgmt_station_model_i.frame(pre, phy_mgmt_pkg::OP_WRITE, phy_addr, ra, wd, rd);
    pre = 0;
    if (ra == phy_mgmt_pkg::AUTONEG_ADVERTISEMENT_ADDR)
      adv_m = wd & phy_mgmt_pkg::ADV_WRITE_MASK;
    repeat (4) @(negedge clock);
    check("adv_word", adv_word, adv_m);
  endtask
  task automatic do_reset();
    @(negedge clock);
    rst_n = 1'h0;
    straps = 4'($urandom);
    repeat (3) @(negedge clock);
    check("adv_reset", adv_word, 16'h0001);
    rst_n = 1'h1;
    adv_m = {7'h0, straps, 5'h01};
    repeat (2) @(negedge clock);
    check("adv_strap", adv_word, adv_m);
    pre = 32;
  endtask
  // ==========================================================
  // Tests
  initial
  begin
    void'($urandom(61));
    phy_addr = 5'($urandom);
    do_reset();
    rd_reg(phy_mgmt_pkg::PHY_IDENT_HIGH_ADDR, phy_mgmt_pkg::ORG_ID_BITS[3:18], "id_hi");
    d = {phy_mgmt_pkg::ORG_ID_BITS[19:24], phy_mgmt_pkg::VENDOR_MODEL, phy_mgmt_pkg::MODEL_REV};
    rd_reg(phy_mgmt_pkg::PHY_IDENT_LOW_ADDR, d, "id_lo");
    wr_reg(phy_mgmt_pkg::PHY_IDENT_LOW_ADDR, ~d);
    rd_reg(phy_mgmt_pkg::PHY_IDENT_LOW_ADDR, d, "id_lo_wr");
    $display("test ident done");
    for (int i = 0; i < 6; i++)
    begin
      d = (i == 0) ? 16'hefff : (i == 1) ? 16'h0000 : 16'($urandom) & 16'hefff;
      wr_reg(phy_mgmt_pkg::AUTONEG_ADVERTISEMENT_ADDR, d);
      rd_reg(phy_mgmt_pkg::AUTONEG_ADVERTISEMENT_ADDR, adv_m, "adv_rd");
    end
    mgmt_station_model_i.frame(0, phy_mgmt_pkg::OP_WRITE, phy_addr ^ 5'h01, 5'h04, 16'ha000, rd);
    rd_reg(phy_mgmt_pkg::AUTONEG_ADVERTISEMENT_ADDR, adv_m, "adv_other_addr");
    $display("test advert done");
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clock);
      an_complete = 1'(i);
      pause_resolved = 2'(3 - i);
      rd_reg(phy_mgmt_pkg::BASIC_MODE_STATUS_ADDR, {10'h0, an_complete, 5'h0}, "status");
      d = {2'h0, pause_resolved, 12'h0};
      rd_reg(phy_mgmt_pkg::TRANSCEIVER_CONTROL_ADDR, d, "pause");
      rd_reg(phy_mgmt_pkg::PHY_IDENT_HIGH_ADDR, phy_mgmt_pkg::ORG_ID_BITS[3:18], "id_hi2");
    end
    rd_reg(5'h07, 16'h0, "unmapped");
    $display("test status done");
    mgmt_station_model_i.frame(0, 2'h3, phy_addr, 5'h04, 16'h0, rd);
    pre = 32;
    wr_reg(phy_mgmt_pkg::AUTONEG_ADVERTISEMENT_ADDR, 16'hac21);
    $display("test bad opcode done");
    do_reset();
    rd_reg(phy_mgmt_pkg::AUTONEG_ADVERTISEMENT_ADDR, adv_m, "adv_rereset");
    $display("test second reset done");
    complete_run();
  end
endmodule
`default_nettype wire
